//--- spisc_pkg.sv
// Package of register offsets, field positions and constants for the SPI regs
package spisc_pkg;
  // Word offsets of the registers on the bus (byte addresses)
  localparam logic [3:0] CONTROL_OFS     = 4'h0;
  localparam logic [3:0] STATUS_CTRL_OFS = 4'h4;
  localparam logic [3:0] DATA_BUF_OFS    = 4'h8;
  // Control register fields
  localparam int TXIE_POS   = 0;
  localparam int ON_POS     = 1;
  localparam int MSTR_POS   = 5;
  localparam int RXIE_POS   = 7;
  // Status/control register fields
  localparam int RATE_LO_POS  = 0;
  localparam int RATE_HI_POS  = 1;
  localparam int FDEN_POS     = 2;
  localparam int TXE_POS      = 3;
  localparam int MODE_FAULT_FLAG_POS     = 4;
  localparam int OVR_POS      = 5;
  localparam int ERROR_IRQ_EN_POS    = 6;
  localparam int RXF_POS      = 7;
  // Reset values: master selected, transmit-empty set, everything else off
  localparam logic [7:0] CONTROL_RST     = 8'h20;
  localparam logic [7:0] STATUS_CTRL_RST = 8'h08;
  // Divisor codes map to half-period counts of base_clock_out cycles
  localparam logic [7:0] DIV_CODE0 = 8'h02;
  localparam logic [7:0] DIV_CODE1 = 8'h08;
  localparam logic [7:0] DIV_CODE2 = 8'h20;
  localparam logic [7:0] DIV_CODE3 = 8'h80;
  localparam int BITS_PER_BYTE = 8;
  // Shift engine states
  typedef enum logic [1:0] {
    SPISC_IDLE = 2'b00,
    SPISC_BUSY = 2'b01,
    SPISC_DONE = 2'b10
  } spisc_state_t;
endpackage

//--- spisc_rate_gen.sv
// Baud tick generator: base clock enable divided by the divisor, one tick per half period
`timescale 1ns/1ps
module spisc_rate_gen
  import spisc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       run,
  input  wire logic       baseTick,
  input  wire logic [1:0] rateSel,
  output logic            halfTick
);
  logic [7:0] divisor;     // Selected divisor
  logic [7:0] cnt_reg;     // Base-tick counter within one half period
  logic [7:0] cnt_next;
  logic       hit;

  // Divisor look-up, one half serial period per divisor base ticks
  assign divisor = (rateSel == 2'b00) ? DIV_CODE0 :
                   (rateSel == 2'b01) ? DIV_CODE1 :
                   (rateSel == 2'b10) ? DIV_CODE2 : DIV_CODE3;
  assign hit      = baseTick && (cnt_reg == divisor - 8'h01);
  assign cnt_next = !run ? 8'h00 :
                    hit  ? 8'h00 :
                    baseTick ? cnt_reg + 8'h01 : cnt_reg;

  // Counter and output tick register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg  <= 8'h00;
      halfTick <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      halfTick <= run && hit;
    end
  end
endmodule

//--- spisc_core.sv
// SPI control, status and data-buffer registers with a minimal shift engine
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
// What this block does
// - Enable bit turns SPI on; clearing partially resets
// - Transmit-empty interrupt enable gates its request
// - Receive-full sets on byte into receive buffer
// - Any data buffer read clears receive-full
// - Error enable gates overrun and mode-fault requests
// - Unread buffer on new byte sets overrun, keeps old
// - Overrun clears on status read then data read
// - Mode fault: slave select high slave, low master
// - Mode fault clears on status read then data write
// - Transmit-empty sets on buffer-to-shifter handoff; reset sets
// - Idle engine loads buffer within two cycles
// - Busy slave defers load until transfer completes
// - Fault enable permits mode fault; clearing keeps flag
// - Master without fault enable releases select pin
// - Slave with fault enable low only suppresses flag
// - Rate select picks divisor 2, 8, 32, 128
// - Serial rate is base clock over twice divisor
// - Separate transmit and receive buffers at one address
// - Master select: 1 master, 0 slave; reset master
// - Receive interrupt enable gates receive-full request
module spisc_core
  import spisc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [3:0] wb_adr_i,
  input  wire logic [7:0] wb_dat_i,
  input  wire logic       wb_we_i,
  input  wire logic       wb_sel_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  output logic [7:0]      wb_dat_o,
  output logic            wb_ack_o,
  output logic            wb_err_o,
  input  wire logic       baseTick,
  input  wire logic       selectPin,
  input  wire logic       sckIn,
  input  wire logic       misoIn,
  input  wire logic       mosiIn,
  output logic            sckOut,
  output logic            sckOe,
  output logic            mosiOut,
  output logic            mosiOe,
  output logic            misoOut,
  output logic            misoOe,
  output logic            selectOwned,
  output logic            rxIrq,
  output logic            txIrq,
  output logic            errIrq
);
  // Register state
  logic [7:0]   ctrl_reg;      // Control register
  logic [7:0]   ctrl_next;
  logic [3:0]   stcfg_reg;     // Writable status/control bits
  logic [3:0]   stcfg_next;
  logic         rxFull_reg;    // Receive-full flag
  logic         overrun_reg;   // Overrun flag
  logic         modeFault_reg; // Mode-fault flag
  logic         txEmpty_reg;   // Transmit-empty flag
  logic         armOvr_reg;    // Overrun clear armed by status read
  logic         armModf_reg;   // Mode-fault clear armed by status read
  logic [7:0]   txBuf_reg;     // Transmit buffer
  logic [7:0]   rxBuf_reg;     // Receive buffer
  logic [7:0]   shift_reg;     // Shift register
  logic [2:0]   bitCnt_reg;    // Bits done in current byte
  logic         sckPhase_reg;  // Master clock level inside a byte
  logic         inBit_reg;     // Sampled bit held until the shift edge
  spisc_state_t state_reg;     // Shift engine state
  spisc_state_t state_next;
  // Pin synchronisers, first stage read only by the second
  logic         ssSync1, sckSync1, misoSync1, mosiSync1;
  logic         ssS, sckS, misoS, mosiS, datS;
  logic         ssPrev, sckPrev;
  // Bus decode
  logic         req, wr, rd;
  logic         hitCtrl, hitStat, hitData;
  logic         rdStat, rdData, wrData;
  logic [7:0]   statusView;
  logic [7:0]   readMux;
  // Engine control
  logic         spiOn, master, faultEn, halfTick;
  logic         load, byteDone, sampleEdge, shiftEdge;
  logic         ssRise, ssFall, sckRise, sckFall;
  logic         modfEvent, slaveSel, engRun;

  // Classic Wishbone slave, one wait state: ack in the cycle after stb
  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr      = req && wb_we_i && wb_sel_i;
  assign rd      = req && !wb_we_i;
  assign hitCtrl = (wb_adr_i == CONTROL_OFS);
  assign hitStat = (wb_adr_i == STATUS_CTRL_OFS);
  assign hitData = (wb_adr_i == DATA_BUF_OFS);
  assign rdStat  = rd && hitStat;
  assign rdData  = rd && hitData;
  assign wrData  = wr && hitData;

  assign spiOn   = ctrl_reg[ON_POS];
  assign master  = ctrl_reg[MSTR_POS];
  assign faultEn = stcfg_reg[FDEN_POS];

  // Status view assembled from flags and writable bits
  assign statusView = {rxFull_reg, stcfg_reg[3], overrun_reg,
                       modeFault_reg, txEmpty_reg, stcfg_reg[2:0]};
  assign readMux = hitCtrl ? ctrl_reg :
                   hitStat ? statusView :
                   hitData ? rxBuf_reg : 8'h00;

  // Register writes; flag bits of status are read-only
  assign ctrl_next  = (wr && hitCtrl) ? wb_dat_i : ctrl_reg;
  assign stcfg_next = (wr && hitStat) ?
                      {wb_dat_i[ERROR_IRQ_EN_POS], wb_dat_i[FDEN_POS],
                       wb_dat_i[RATE_HI_POS], wb_dat_i[RATE_LO_POS]} :
                      stcfg_reg;

  // Bus answer registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 8'h00;
    end else begin
      wb_ack_o <= req && (hitCtrl || hitStat || hitData);
      wb_err_o <= req && !(hitCtrl || hitStat || hitData);
      wb_dat_o <= rd ? readMux : wb_dat_o;
    end
  end

  // Configuration registers; system reset selects master, all else off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg  <= CONTROL_RST;
      stcfg_reg <= 4'h0;
    end else begin
      ctrl_reg  <= ctrl_next;
      stcfg_reg <= stcfg_next;
    end
  end

  // Two-flop synchronisers for select, clock and data pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ssSync1   <= 1'b1;
      ssS       <= 1'b1;
      sckSync1  <= 1'b0;
      sckS      <= 1'b0;
      misoSync1 <= 1'b0;
      misoS     <= 1'b0;
      mosiSync1 <= 1'b0;
      mosiS     <= 1'b0;
      ssPrev    <= 1'b1;
      sckPrev   <= 1'b0;
    end else begin
      ssSync1   <= selectPin;
      ssS       <= ssSync1;
      sckSync1  <= sckIn;
      sckS      <= sckSync1;
      misoSync1 <= misoIn;
      misoS     <= misoSync1;
      mosiSync1 <= mosiIn;
      mosiS     <= mosiSync1;
      ssPrev    <= ssS;
      sckPrev   <= sckS;
    end
  end

  // Edges seen after synchronisation only
  assign ssRise  = ssS && !ssPrev;
  assign ssFall  = !ssS && ssPrev;
  assign sckRise = sckS && !sckPrev;
  assign sckFall = !sckS && sckPrev;
  assign slaveSel = !ssS;
  // Data pin picked after both are synchronised, so no mux glitch is caught
  assign datS     = master ? misoS : mosiS;

  // Mode fault: slave loses select mid-byte, or master sees select low
  assign modfEvent = spiOn && faultEn &&
                     (master ? (ssFall || !ssS)
                             : (ssRise && state_reg == SPISC_BUSY));

  // Serial tick generator, only running for an active master
  assign engRun = spiOn && master && (state_reg == SPISC_BUSY);
  spisc_rate_gen u_rate (
    .clk      (clk),
    .nrst     (nrst),
    .run      (engRun),
    .baseTick (baseTick),
    .rateSel  (stcfg_reg[1:0]),
    .halfTick (halfTick)
  );

  // Master samples on its rising half tick, slave on synced clock edges
  assign sampleEdge = master ? (halfTick && !sckPhase_reg)
                             : (sckRise && slaveSel);
  assign shiftEdge  = master ? (halfTick && sckPhase_reg)
                             : (sckFall && slaveSel);
  assign byteDone   = (state_reg == SPISC_BUSY) && shiftEdge &&
                      (bitCnt_reg == 3'(BITS_PER_BYTE - 1));
  // Load only when idle, so a busy slave waits for its byte to finish
  assign load = spiOn && !txEmpty_reg &&
                (state_reg == SPISC_IDLE);

  // Engine next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SPISC_IDLE: begin
        if (load) begin
          state_next = SPISC_BUSY;
        end
      end
      SPISC_BUSY: begin
        if (byteDone) begin
          state_next = SPISC_DONE;
        end
      end
      SPISC_DONE: begin
        state_next = SPISC_IDLE;
      end
      default: begin
        state_next = SPISC_IDLE;
      end
    endcase
  end

  // Shift engine; disabling the module is the partial reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= SPISC_IDLE;
      shift_reg    <= 8'h00;
      bitCnt_reg   <= 3'd0;
      sckPhase_reg <= 1'b0;
      inBit_reg    <= 1'b0;
    end else if (!spiOn) begin
      state_reg    <= SPISC_IDLE;
      bitCnt_reg   <= 3'd0;
      sckPhase_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (load) begin
        shift_reg  <= txBuf_reg;
        bitCnt_reg <= 3'd0;
      end else if (state_reg == SPISC_BUSY) begin
        // Sample on the leading edge, shift on the trailing one, so the
        // outgoing bit stays still while the far side samples it
        if (sampleEdge) begin
          inBit_reg <= datS;
        end
        if (shiftEdge) begin
          shift_reg  <= {shift_reg[6:0], inBit_reg};
          bitCnt_reg <= bitCnt_reg + 3'd1;
        end
        if (master && halfTick) begin
          sckPhase_reg <= !sckPhase_reg;
        end
      end
    end
  end

  // Buffers: transmit written by software, receive filled by engine
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txBuf_reg <= 8'h00;
      rxBuf_reg <= 8'h00;
    end else begin
      if (wrData) begin
        txBuf_reg <= wb_dat_i;
      end
      if (state_reg == SPISC_DONE && !rxFull_reg) begin
        rxBuf_reg <= shift_reg;
      end
    end
  end

  // Status flags; hardware set wins over a same-cycle clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxFull_reg    <= 1'b0;
      overrun_reg   <= 1'b0;
      modeFault_reg <= 1'b0;
      txEmpty_reg   <= 1'b1;
      armOvr_reg    <= 1'b0;
      armModf_reg   <= 1'b0;
    end else begin
      // Receive-full: set on transfer, any data read clears it
      if (state_reg == SPISC_DONE && !rxFull_reg) begin
        rxFull_reg <= 1'b1;
      end else if (rdData) begin
        rxFull_reg <= 1'b0;
      end
      // Overrun: second byte with buffer still full
      if (state_reg == SPISC_DONE && rxFull_reg) begin
        overrun_reg <= 1'b1;
      end else if (rdData && armOvr_reg) begin
        overrun_reg <= 1'b0;
      end
      // Mode fault: enable low stops new sets but keeps an old flag
      if (modfEvent) begin
        modeFault_reg <= 1'b1;
      end else if (wrData && armModf_reg) begin
        modeFault_reg <= 1'b0;
      end
      // Transmit-empty: cleared by a data write, set at handoff
      if (load) begin
        txEmpty_reg <= 1'b1;
      end else if (wrData) begin
        txEmpty_reg <= 1'b0;
      end
      // Arm states captured by a status read seeing the flag set
      if (rdStat) begin
        armOvr_reg  <= overrun_reg;
        armModf_reg <= modeFault_reg;
      end else begin
        if (rdData) begin
          armOvr_reg <= 1'b0;
        end
        if (wrData) begin
          armModf_reg <= 1'b0;
        end
      end
    end
  end

  // Pin drivers and interrupt requests, all registered
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sckOut      <= 1'b0;
      sckOe       <= 1'b0;
      mosiOut     <= 1'b0;
      mosiOe      <= 1'b0;
      misoOut     <= 1'b0;
      misoOe      <= 1'b0;
      selectOwned <= 1'b0;
      rxIrq       <= 1'b0;
      txIrq       <= 1'b0;
      errIrq      <= 1'b0;
    end else begin
      sckOut      <= sckPhase_reg;
      sckOe       <= spiOn && master;
      mosiOut     <= shift_reg[7];
      mosiOe      <= spiOn && master;
      misoOut     <= shift_reg[7];
      misoOe      <= spiOn && !master && slaveSel;
      selectOwned <= spiOn && (!master || faultEn);
      rxIrq <= rxFull_reg && ctrl_reg[RXIE_POS];
      txIrq <= txEmpty_reg && ctrl_reg[TXIE_POS];
      errIrq <= stcfg_reg[3] && (overrun_reg || modeFault_reg);
    end
  end
endmodule

//--- spisc_core_chk.sv
// Port-level assertions for the SPI register block, with its bind
`timescale 1ns/1ps
module spisc_core_chk
  import spisc_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [3:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic       wb_we_i,
  input wire logic       wb_sel_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic [7:0] wb_dat_o,
  input wire logic       wb_ack_o,
  input wire logic       wb_err_o,
  input wire logic       selectOwned,
  input wire logic       rxIrq,
  input wire logic       txIrq,
  input wire logic       errIrq
);
  logic [7:0] ctlReg;    // Shadow of the control register
  logic [7:0] statReg;   // Shadow of the status/control enables
  logic [1:0] quietReg;  // Cycles since the last write, saturating
  // A new request is taken at this edge
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire logic wrDone = wb_ack_o && wb_we_i && wb_sel_i;
  wire logic mapped = wb_adr_i == CONTROL_OFS ||
    wb_adr_i == STATUS_CTRL_OFS || wb_adr_i == DATA_BUF_OFS;
  // Outputs are registered and lag a write, so gates wait to settle
  wire logic settled = quietReg == 2'h3;
  // Shadow registers follow each completed write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctlReg   <= CONTROL_RST;
      statReg  <= STATUS_CTRL_RST;
      quietReg <= 2'h0;
    end else begin
      if (wrDone && wb_adr_i == CONTROL_OFS) ctlReg <= wb_dat_i;
      if (wrDone && wb_adr_i == STATUS_CTRL_OFS) statReg <= wb_dat_i;
      quietReg <= wrDone ? 2'h0 : quietReg + {1'b0, !settled};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_answer_next_cycle: assert property (req |=> wb_ack_o || wb_err_o)
    else $error("request not answered in one cycle");
  a_err_unmapped: assert property (req && !mapped |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  a_ctl_readback: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == CONTROL_OFS |-> (wb_dat_o & 8'hA3) == (ctlReg & 8'hA3))
    else $error("control readback differs");
  a_select_owner: assert property (settled |-> selectOwned ==
    (ctlReg[ON_POS] && (!ctlReg[MSTR_POS] || statReg[FDEN_POS])))
    else $error("select pin ownership wrong");
  a_tx_irq_gate: assert property (settled && !ctlReg[TXIE_POS] |-> !txIrq)
    else $error("transmit request while disabled");
  a_rx_irq_gate: assert property (settled && !ctlReg[RXIE_POS] |-> !rxIrq)
    else $error("receive request while disabled");
  a_err_irq_gate: assert property (settled && !statReg[ERROR_IRQ_EN_POS] |-> !errIrq)
    else $error("error request while disabled");
endmodule
bind spisc_core spisc_core_chk i_chk (.clk, .nrst, .wb_adr_i, .wb_dat_i,
  .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .wb_err_o, .selectOwned, .rxIrq, .txIrq, .errIrq);

//--- spisc_peer.sv
// Remote SPI slave that answers the block's master clock
`timescale 1ns/1ps
module spisc_peer (
  input  wire logic clk,
  input  wire logic sck,
  input  wire logic sckOe,
  input  wire logic mosi,
  output logic      miso
);
  logic [7:0] shiftReg = 8'h5A;  // Reply byte; then the last byte heard
  logic       sckLast = 1'b0;    // Clock level at the previous edge
  // Loopback slave: each frame returns the byte heard in the frame before
  assign miso = shiftReg[7];
  // Undriven clock means the master is off: start again from the reply
  always @(posedge clk) begin
    sckLast <= sck;
    if (!sckOe) begin
      shiftReg <= 8'h5A;
    end else if (sck && !sckLast) begin
      shiftReg <= {shiftReg[6:0], mosi};
    end
  end
endmodule

//--- spi_status_control_data_regs_tb.sv
// Register-level bench for the SPI control, status and data block
`timescale 1ns/1ps
module spi_status_control_data_regs_tb;
  import spisc_pkg::*;
  logic       clk = 1'b0, nrst = 1'b0, baseTick = 1'b0, selectPin = 1'b1;
  logic [3:0] wb_adr_i = 4'h0;
  logic [7:0] wb_dat_i = 8'h00;
  logic       wb_we_i = 1'b0, wb_sel_i = 1'b0;
  logic       wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [7:0] wb_dat_o, rdat;
  logic       wb_ack_o, wb_err_o, errSeen, misoW;
  logic       sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe;
  logic       selectOwned, rxIrq, txIrq, errIrq;
  int         fail_count = 0, total_checks = 0, cnt;
  logic       lvl;
  always #10 clk = ~clk;
  // Base clock enable every second bus clock
  always @(posedge clk) baseTick <= ~baseTick;
  spisc_core i_dut (.clk, .nrst, .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_sel_i,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .baseTick,
    .selectPin, .sckIn(sckOut), .misoIn(misoW), .mosiIn(mosiOut), .sckOut,
    .sckOe, .mosiOut, .mosiOe, .misoOut, .misoOe, .selectOwned, .rxIrq,
    .txIrq, .errIrq);
  spisc_peer i_peer (.clk, .sck(sckOut), .sckOe, .mosi(mosiOut),
    .miso(misoW));
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One classic cycle; data is never read-modified-written
  task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_sel_i <= 1'b1;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
      chk("bus answer", 16'h0000, 16'h0001);
    end
    rdat = wb_dat_o;
    errSeen = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Write, then let the registered outputs settle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wb(a, 1'b1, d);
    repeat (3) @(posedge clk);
  endtask
  task automatic rdc(input string nm, input logic [3:0] a,
                     input logic [7:0] m, e);
    wb(a, 1'b0, 8'h00);
    chk(nm, {8'h00, rdat & m}, {8'h00, e});
  endtask
  // Poll status until one flag reads high, bounded
  task automatic waitSt(input string nm, input int b);
    int i;
    i = 0;
    do begin
      wb(STATUS_CTRL_OFS, 1'b0, 8'h00);
      i++;
    end while (rdat[b] !== 1'b1 && i < 2000);
    chk(nm, {15'h0000, rdat[b]}, 16'h0001);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #1_500_000;
    fail_count++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rdc("control reset", CONTROL_OFS, 8'hFF, 8'h20);
    rdc("status reset", STATUS_CTRL_OFS, 8'hFF, 8'h08);
    wb(4'hC, 1'b0, 8'h00);
    chk("unmapped err", {15'h0000, errSeen}, 16'h0001);
    wr(CONTROL_OFS, 8'h23);
    chk("owned no fault", {15'h0000, selectOwned}, 16'h0000);
    chk("tx irq on", {15'h0000, txIrq}, 16'h0001);
    wr(STATUS_CTRL_OFS, 8'h04);
    chk("owned fault", {15'h0000, selectOwned}, 16'h0001);
    wr(CONTROL_OFS, 8'h03);
    chk("owned slave", {15'h0000, selectOwned}, 16'h0001);
    wr(CONTROL_OFS, 8'h22);
    chk("tx irq off", {15'h0000, txIrq}, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr(STATUS_CTRL_OFS, c[7:0]);
      wb(DATA_BUF_OFS, 1'b1, 8'h3C);
      rdc("tx empty again", STATUS_CTRL_OFS, 8'h08, 8'h08);
      lvl = sckOut;
      cnt = 0;
      while (sckOut === lvl && cnt < 600) begin
        @(posedge clk);
        cnt++;
      end
      lvl = sckOut;
      cnt = 0;
      do begin
        @(posedge clk);
        cnt++;
      end while (sckOut === lvl && cnt < 600);
      chk("half period", cnt[15:0], 16'h0004 << (2 * c));
      waitSt("rx full", RXF_POS);
      rdc("data read", DATA_BUF_OFS, 8'hFF,
          (c == 0) ? 8'h5A : 8'h3C);
      rdc("rx full cleared", STATUS_CTRL_OFS, 8'h80, 8'h00);
    end
    wr(CONTROL_OFS, 8'hA2);
    wr(STATUS_CTRL_OFS, 8'h40);
    wb(DATA_BUF_OFS, 1'b1, 8'h81);
    waitSt("first byte", RXF_POS);
    chk("rx irq", {15'h0000, rxIrq}, 16'h0001);
    wb(DATA_BUF_OFS, 1'b1, 8'h7E);
    waitSt("overrun", OVR_POS);
    repeat (3) @(posedge clk);
    chk("err irq", {15'h0000, errIrq}, 16'h0001);
    rdc("both flags", STATUS_CTRL_OFS, 8'hA0, 8'hA0);
    rdc("second byte lost", DATA_BUF_OFS, 8'hFF, 8'h3C);
    rdc("overrun cleared", STATUS_CTRL_OFS, 8'hA0, 8'h00);
    wr(STATUS_CTRL_OFS, 8'h44);
    selectPin <= 1'b0;
    repeat (8) @(posedge clk);
    rdc("master fault", STATUS_CTRL_OFS, 8'h10, 8'h10);
    wr(STATUS_CTRL_OFS, 8'h40);
    selectPin <= 1'b1;
    rdc("fault kept", STATUS_CTRL_OFS, 8'h10, 8'h10);
    wr(DATA_BUF_OFS, 8'h55);
    rdc("fault cleared", STATUS_CTRL_OFS, 8'h10, 8'h00);
    wr(CONTROL_OFS, 8'h00);
    chk("off owned", {15'h0000, selectOwned}, 16'h0000);
    // Slave: a busy engine keeps the second byte, select rise is a fault
    wr(CONTROL_OFS, 8'h02);
    wr(STATUS_CTRL_OFS, 8'h44);
    selectPin <= 1'b0;
    wr(DATA_BUF_OFS, 8'h66);
    wb(DATA_BUF_OFS, 1'b1, 8'h77);
    rdc("slave defers", STATUS_CTRL_OFS, 8'h08, 8'h00);
    selectPin <= 1'b1;
    repeat (8) @(posedge clk);
    rdc("slave fault", STATUS_CTRL_OFS, 8'h10, 8'h10);
    conclude();
  end
endmodule
